// ### hw/qpc_params.svh
// constants of the quadrature position counter: mode codes and reset values
// assumes it is included by the package and the design files by bare name
`ifndef QPC_PARAMS_SVH
`define QPC_PARAMS_SVH

// counter width and reset values
`define QPC_CNT_W 32
`define QPC_CNT_RST 32'h0000_0000
`define QPC_CNT_ZERO 32'h0000_0000
`define QPC_CNT_ONE 32'h0000_0001

// count source select codes
`define QPC_SRC_QUAD 2'h0
`define QPC_SRC_DIR 2'h1
`define QPC_SRC_UP 2'h2
`define QPC_SRC_DOWN 2'h3

// counter reset mode codes
`define QPC_RM_INDEX 2'h0
`define QPC_RM_MAX 2'h1
`define QPC_RM_FIRST 2'h2
`define QPC_RM_UNIT 2'h3

// index latch select codes, ignored in reset-on-index mode
`define QPC_IL_NONE 2'h0
`define QPC_IL_RISE 2'h1
`define QPC_IL_FALL 2'h2
`define QPC_IL_MARK 2'h3

// synchroniser reset level of the pin samples
`define QPC_PIN_RST 4'h0

`endif

// ### hw/qpc_pkg.sv
// types shared by the decoder and the position counter
// assumes qpc_params.svh sits in the include path
`include "qpc_params.svh"

package qpc_pkg;

  // decoder control bits, driven by software as plain ports
  typedef struct packed {
    logic [1:0] count_source_select;
    logic swap;
    logic double_resolution_bit;
    logic phase_a_invert;
    logic phase_b_invert;
    logic index_invert_bit;
    logic strobe_invert;
    logic sync_output_enable;
    logic sync_pin_select;
  } qpc_dec_ctl_t;

  // counter control bits
  typedef struct packed {
    logic [1:0] reset_mode_field;
    logic [1:0] index_latch_select;
  } qpc_cnt_ctl_t;

  // status bits shown to software
  typedef struct packed {
    logic first_marker_seen;
    logic first_marker_direction;
    logic latched_direction_bit;
    logic counter_error_status;
  } qpc_status_t;

  // sticky flags, same layout is used for the clear strobes
  typedef struct packed {
    logic phase_error_flag;
    logic overflow_flag;
    logic underflow_flag;
    logic counter_error_irq_flag;
    logic compare_match_flag;
    logic index_latch_flag;
  } qpc_flags_t;

  // one-cycle events from the decoder to the counter
  typedef struct packed {
    logic count_pulse;
    logic count_direction;
    logic phase_error;
    logic index_rise;
    logic index_fall;
    logic edge_is_b;
    logic edge_level;
  } qpc_dec_evt_t;

endpackage

// ### hw/qpc_decoder.sv
// decoder unit: pin synchronisers, polarity, swap and count pulse generation
// assumes raw encoder pins are asynchronous to mclk
`timescale 1ns/1ps
`include "qpc_params.svh"

module qpc_decoder (
  input wire logic mclk,
  input wire logic reset,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic strobe_input,
  input wire qpc_pkg::qpc_dec_ctl_t dec_ctl,
  output qpc_pkg::qpc_dec_evt_t evt,
  output logic strobe_level
);
  import qpc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] meta_r; // first stage, read only by sync_r
  logic [3:0] sync_r; // second stage
  logic [3:0] prev_r; // previous qualified sample
  logic [3:0] qual_nxt; // qualified sample after polarity, before swap
  qpc_dec_evt_t evt_r;
  qpc_dec_evt_t evt_nxt;
  logic dir_r;
  logic dir_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // next-value logic: bit order a, b, index, strobe
  always_comb begin
    logic a_n;
    logic b_n;
    logic a_e;
    logic b_e;
    a_n = 1'b0;
    b_n = 1'b0;
    a_e = 1'b0;
    b_e = 1'b0;
    // polarity before decoding
    qual_nxt[0] = sync_r[0] ^ dec_ctl.phase_a_invert;
    qual_nxt[1] = sync_r[1] ^ dec_ctl.phase_b_invert;
    qual_nxt[2] = sync_r[2] ^ dec_ctl.index_invert_bit;
    qual_nxt[3] = sync_r[3] ^ dec_ctl.strobe_invert;
    // swap exchanges the phases, reversing direction
    a_n = dec_ctl.swap ? qual_nxt[1] : qual_nxt[0];
    b_n = dec_ctl.swap ? qual_nxt[0] : qual_nxt[1];
    // edges by comparing successive samples
    a_e = a_n ^ prev_r[0];
    b_e = b_n ^ prev_r[1];
    evt_nxt = '0;
    dir_nxt = dir_r;
    evt_nxt.index_rise = qual_nxt[2] & ~prev_r[2];
    evt_nxt.index_fall = ~qual_nxt[2] & prev_r[2];
    case (dec_ctl.count_source_select)
      `QPC_SRC_QUAD: begin
        // both phases moving in one sample is illegal: no count
        evt_nxt.phase_error = a_e & b_e;
        if (a_e && !b_e) begin
          dir_nxt = a_n ^ b_n;
          evt_nxt.count_pulse = 1'b1;
          evt_nxt.edge_level = a_n;
        end else if (b_e && !a_e) begin
          dir_nxt = ~(a_n ^ b_n);
          evt_nxt.count_pulse = 1'b1;
          evt_nxt.edge_is_b = 1'b1;
          evt_nxt.edge_level = b_n;
        end
      end
      `QPC_SRC_DIR: begin
        // phase a is the clock, phase b the direction
        dir_nxt = b_n;
        evt_nxt.count_pulse = a_n & ~prev_r[0];
        evt_nxt.edge_level = 1'b1;
      end
      `QPC_SRC_UP: begin
        dir_nxt = 1'b1;
        evt_nxt.count_pulse = dec_ctl.double_resolution_bit ? a_e : (a_n & a_e);
        evt_nxt.edge_level = a_n;
      end
      default: begin
        dir_nxt = 1'b0;
        evt_nxt.count_pulse = dec_ctl.double_resolution_bit ? a_e : (a_n & a_e);
        evt_nxt.edge_level = a_n;
      end
    endcase
    evt_nxt.count_direction = dir_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_r <= `QPC_PIN_RST;
      sync_r <= `QPC_PIN_RST;
      prev_r <= `QPC_PIN_RST;
      evt_r <= '0;
      dir_r <= 1'b1;
    end else begin
      meta_r <= {strobe_input, index_input, phase_b_input, phase_a_input};
      sync_r <= meta_r;
      prev_r <= {qual_nxt[3:2], dec_ctl.swap ? qual_nxt[0] : qual_nxt[1],
                 dec_ctl.swap ? qual_nxt[1] : qual_nxt[0]};
      evt_r <= evt_nxt;
      dir_r <= dir_nxt;
    end
  end

  assign evt = evt_r;
  assign strobe_level = prev_r[3];

endmodule

// ### hw/qpc_counter.sv
// position counter and control unit with its decoder instance
// assumes config ports come from software registers on mclk, pins are async
`timescale 1ns/1ps
`include "qpc_params.svh"

// Functional notes
// - two-bit field selects four count sources
// - quadrature counts every edge, leading phase sets direction
// - in quadrature, simultaneous phase edges set phase error flag
// - swap bit exchanges phases before decoding
// - direction mode: a clocks, b gives direction
// - up mode counts a rises, both if doubled
// - down mode counts a rises, both if doubled
// - four polarity bits invert inputs, one index
// - compare sync high while counter equals compare
// - sync enable gates pin, select picks pin
// - up past maximum wraps zero, down loads maximum
// - wraps set overflow or underflow flag
// - two-bit field picks one of four resets
// - index mode: marker clears forward, maximum reverse
// - first edge after index is first marker
// - later markers align to same relative edge
// - index mode latches counter and direction at marker
// - index mode marker updates error status, sticky error flag
// - index mode ignores latch select, only errors
// - maximum mode resets at limits, sets flags
// - maximum mode still records first marker
module qpc_counter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic strobe_input,
  input wire qpc_pkg::qpc_dec_ctl_t decoder_control_reg,
  input wire qpc_pkg::qpc_cnt_ctl_t counter_control_reg,
  input wire logic [31:0] position_maximum,
  input wire logic [31:0] position_compare_value,
  input wire logic unit_timeout,
  input wire qpc_pkg::qpc_flags_t flag_clear,
  output logic [31:0] position_counter,
  output logic [31:0] index_latch_reg,
  output logic count_pulse,
  output logic count_direction,
  output qpc_pkg::qpc_status_t counter_status_reg,
  output qpc_pkg::qpc_flags_t interrupt_flag_reg,
  output logic compare_sync,
  output logic index_pin_out,
  output logic index_pin_oe,
  output logic strobe_pin_out,
  output logic strobe_pin_oe,
  output logic strobe_level
);
  import qpc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helper functions

  // reload value after a reset event: zero forward, maximum reverse
  function automatic logic [31:0] reset_target(input logic up,
    input logic [31:0] max);
    reset_target = up ? `QPC_CNT_ZERO : max;
  endfunction

  // one count step with wrap at both ends
  function automatic logic [31:0] step(input logic up, input logic [31:0] cnt,
                                       input logic [31:0] max);
    if (up) begin
      step = (cnt == max) ? `QPC_CNT_ZERO : cnt + `QPC_CNT_ONE;
    end else begin
      step = (cnt == `QPC_CNT_ZERO) ? max : cnt - `QPC_CNT_ONE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decoder unit
  qpc_dec_evt_t evt; // one-cycle events from the decoder

  qpc_decoder u_decoder (
    .mclk(mclk),
    .reset(reset),
    .phase_a_input(phase_a_input),
    .phase_b_input(phase_b_input),
    .index_input(index_input),
    .strobe_input(strobe_input),
    .dec_ctl(decoder_control_reg),
    .evt(evt),
    .strobe_level(strobe_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state of the counter group
  logic [31:0] cnt_r; // position counter
  logic [31:0] cnt_nxt;
  logic [31:0] latch_r; // index latch
  logic [31:0] latch_nxt;
  qpc_status_t sts_r; // status bits
  qpc_status_t sts_nxt;
  qpc_flags_t flg_r; // sticky flags
  qpc_flags_t flg_nxt;
  logic armed_r; // index edge seen, waiting for the marker edge
  logic armed_nxt;
  logic edge_b_r; // phase of the first marker edge
  logic edge_b_nxt;
  logic edge_lvl_r; // level of the first marker edge
  logic edge_lvl_nxt;

  logic sync_r; // compare sync
  logic sync_nxt;
  logic [3:0] pin_r; // index out, index oe, strobe out, strobe oe
  logic [3:0] pin_nxt;

  logic pulse_r; // count pulse as seen by the counter
  logic dir_r; // direction as seen by the counter

  // marker detection, shared by the reset and latch paths
  logic marker; // index event marker this cycle
  logic rel_lvl; // expected level of the aligned edge
  logic ovf; // wrap up this cycle
  logic unf; // wrap down this cycle
  logic do_latch; // index latch taken this cycle

  //////////////////////////////////////////////////////////////////////////////
  // next-value logic
  always_comb begin
    // direction change relative to the first marker flips the expected level
    rel_lvl = edge_lvl_r ^ (evt.count_direction != sts_r.first_marker_direction);
    // the first marker is any count edge; later ones must line up
    marker = evt.count_pulse & armed_r &
             (~sts_r.first_marker_seen |
              ((evt.edge_is_b == edge_b_r) & (evt.edge_level == rel_lvl)));

    // arming: a new index edge wins over the marker that disarms
    armed_nxt = armed_r;
    if (evt.index_rise) begin
      armed_nxt = 1'b1;
    end else if (marker) begin
      armed_nxt = 1'b0;
    end

    // counter update
    cnt_nxt = cnt_r;
    ovf = 1'b0;
    unf = 1'b0;
    case (counter_control_reg.reset_mode_field)
      `QPC_RM_INDEX: begin
        if (marker) begin
          // the marker edge itself reloads instead of counting
          cnt_nxt = reset_target(evt.count_direction, position_maximum);
        end else if (evt.count_pulse) begin
          cnt_nxt = step(evt.count_direction, cnt_r, position_maximum);
        end
      end
      `QPC_RM_FIRST: begin
        if (marker && !sts_r.first_marker_seen) begin
          cnt_nxt = reset_target(evt.count_direction, position_maximum);
        end else if (evt.count_pulse) begin
          cnt_nxt = step(evt.count_direction, cnt_r, position_maximum);
        end
      end
      `QPC_RM_UNIT: begin
        if (unit_timeout) begin
          cnt_nxt = reset_target(evt.count_direction, position_maximum);
        end else if (evt.count_pulse) begin
          cnt_nxt = step(evt.count_direction, cnt_r, position_maximum);
        end
      end
      default: begin
        // reset on maximum: plain wrap at both limits
        if (evt.count_pulse) begin
          cnt_nxt = step(evt.count_direction, cnt_r, position_maximum);
        end
      end
    endcase

    // wraps are taken only from a counting step, not from a reload
    if (evt.count_pulse && !(marker && counter_control_reg.reset_mode_field == `QPC_RM_INDEX)
        && !(counter_control_reg.reset_mode_field == `QPC_RM_UNIT && unit_timeout)
        && !(marker && !sts_r.first_marker_seen
             && counter_control_reg.reset_mode_field == `QPC_RM_FIRST)) begin
      ovf = evt.count_direction & (cnt_r == position_maximum);
      unf = ~evt.count_direction & (cnt_r == `QPC_CNT_ZERO);
    end

    // first marker record, kept in every reset mode
    sts_nxt = sts_r;
    edge_b_nxt = edge_b_r;
    edge_lvl_nxt = edge_lvl_r;

    if (marker && !sts_r.first_marker_seen) begin
      sts_nxt.first_marker_seen = 1'b1;
      sts_nxt.first_marker_direction = evt.count_direction;
      edge_b_nxt = evt.edge_is_b;
      edge_lvl_nxt = evt.edge_level;
    end

    // index latch: latch select is ignored in reset-on-index mode
    do_latch = 1'b0;
    if (counter_control_reg.reset_mode_field == `QPC_RM_INDEX) begin
      do_latch = marker;
    end else begin
      case (counter_control_reg.index_latch_select)
        `QPC_IL_RISE: do_latch = evt.index_rise;
        `QPC_IL_FALL: do_latch = evt.index_fall;
        `QPC_IL_MARK: do_latch = marker;
        default: do_latch = 1'b0;
      endcase
    end

    latch_nxt = latch_r;
    if (do_latch) begin
      latch_nxt = cnt_r;
      sts_nxt.latched_direction_bit = evt.count_direction;
    end

    // error check only in reset-on-index mode
    if (marker && counter_control_reg.reset_mode_field == `QPC_RM_INDEX) begin
      sts_nxt.counter_error_status = (cnt_r != `QPC_CNT_ZERO) &&
                                     (cnt_r != position_maximum);
    end

    // compare sync follows the counter value
    sync_nxt = (cnt_nxt == position_compare_value);


    // sticky flags: a set in the clear cycle wins
    flg_nxt = flg_r & ~flag_clear;
    if (evt.phase_error) begin
      flg_nxt.phase_error_flag = 1'b1;
    end
    if (ovf) begin
      flg_nxt.overflow_flag = 1'b1;
    end
    if (unf) begin
      flg_nxt.underflow_flag = 1'b1;
    end
    if (marker && counter_control_reg.reset_mode_field == `QPC_RM_INDEX &&
        sts_nxt.counter_error_status) begin
      flg_nxt.counter_error_irq_flag = 1'b1;
    end
    if (sync_nxt && !sync_r) begin
      flg_nxt.compare_match_flag = 1'b1;
    end
    if (do_latch) begin
      flg_nxt.index_latch_flag = 1'b1;
    end

    // sync routed to both pins, enable only while selected
    pin_nxt[3] = sync_nxt;
    pin_nxt[2] = decoder_control_reg.sync_output_enable &
                 ~decoder_control_reg.sync_pin_select;
    pin_nxt[1] = sync_nxt;
    pin_nxt[0] = decoder_control_reg.sync_output_enable &
                 decoder_control_reg.sync_pin_select;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_r <= `QPC_CNT_RST;
      latch_r <= `QPC_CNT_RST;
      sts_r <= '0;
      flg_r <= '0;
      armed_r <= 1'b0;
      edge_b_r <= 1'b0;
      edge_lvl_r <= 1'b0;
      sync_r <= 1'b0;
      pin_r <= 4'h0;
      pulse_r <= 1'b0;
      dir_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      latch_r <= latch_nxt;
      sts_r <= sts_nxt;
      flg_r <= flg_nxt;
      armed_r <= armed_nxt;
      edge_b_r <= edge_b_nxt;
      edge_lvl_r <= edge_lvl_nxt;
      sync_r <= sync_nxt;
      pin_r <= pin_nxt;
      pulse_r <= evt.count_pulse;
      dir_r <= evt.count_direction;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign position_counter = cnt_r;
  assign index_latch_reg = latch_r;
  assign counter_status_reg = sts_r;
  assign interrupt_flag_reg = flg_r;
  assign compare_sync = sync_r;
  assign count_pulse = pulse_r;
  assign count_direction = dir_r;

  assign index_pin_out = pin_r[3];
  assign index_pin_oe = pin_r[2];
  assign strobe_pin_out = pin_r[1];
  assign strobe_pin_oe = pin_r[0];

endmodule

// ### test/qpc_encoder_model.sv
// encoder model: phase, index and strobe pins of an incremental encoder
// assumes the caller starts each action just after a falling edge of mclk
`timescale 1ns/1ps
module qpc_encoder_model (
  input wire logic mclk,
  output logic phase_a,
  output logic phase_b,
  output logic index_out,
  output logic strobe_out
);
  logic [1:0] ph; // gray position, forward order ab = 00 10 11 01
  // pins start low
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index_out = 1'b0;
    strobe_out = 1'b0;
    ph = 2'h0;
  end
  // each new level is held four cycles, twice the two-sample minimum
  task automatic hold();
    repeat (4) @(negedge mclk);
  endtask
  // quadrature steps; position is re-derived since other tasks move a alone
  task automatic step(input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      ph = {phase_b, phase_a ^ phase_b};
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      phase_a = ph[1] ^ ph[0];
      phase_b = ph[1];
      hold();
    end
  endtask
  // toggle a only: count clock for direction and up/down sources
  task automatic tog_a(input int n);
    for (int i = 0; i < n; i++) begin
      phase_a = ~phase_a;
      hold();
    end
  endtask
  // direction level on b
  task automatic set_b(input logic v);
    phase_b = v;
    hold();
  endtask
  // both phases in one sample: an illegal encoder jump
  task automatic both();
    phase_a = ~phase_a;
    phase_b = ~phase_b;
    hold();
  endtask
  // strobe level
  task automatic stb(input logic v);
    strobe_out = v;
    hold();
  endtask
  // index pulse, rise then fall, with no phase motion
  task automatic idx();
    index_out = 1'b1;
    hold();
    index_out = 1'b0;
    hold();
  endtask
endmodule

// ### test/qpc_counter_asserts.sv
// checker of the position counter ports: counting, wraps, compare, errors
// assumes it is bound to qpc_counter and sees only its ports
`timescale 1ns/1ps
module qpc_counter_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire qpc_pkg::qpc_dec_ctl_t decoder_control_reg,
  input wire qpc_pkg::qpc_cnt_ctl_t counter_control_reg,
  input wire logic [31:0] position_maximum,
  input wire logic [31:0] position_compare_value,
  input wire qpc_pkg::qpc_flags_t flag_clear,
  input wire logic [31:0] position_counter,
  input wire logic [31:0] index_latch_reg,
  input wire logic count_pulse,
  input wire logic count_direction,
  input wire qpc_pkg::qpc_status_t counter_status_reg,
  input wire qpc_pkg::qpc_flags_t interrupt_flag_reg,
  input wire logic compare_sync,
  input wire logic index_pin_oe,
  input wire logic strobe_pin_oe
);
  import qpc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic wm; // reset-on-maximum mode: no marker reloads, only wraps
  assign wm = counter_control_reg.reset_mode_field == 2'h1;
  ////////////////////////////////////////////////////////////////////
  // compare and sync pins lag their causes by one edge
  a_sync_match: assert property (!$past(reset) |-> compare_sync ==
    (position_counter == $past(position_compare_value))) else $error("sync mismatch");
  a_index_pin_oe: assert property (!$past(reset) |-> index_pin_oe ==
    ($past(decoder_control_reg.sync_output_enable) && !$past(decoder_control_reg.sync_pin_select)))
    else $error("index oe wrong");
  a_strobe_pin_oe: assert property (!$past(reset) |-> strobe_pin_oe ==
    ($past(decoder_control_reg.sync_output_enable) && $past(decoder_control_reg.sync_pin_select)))
    else $error("strobe oe wrong");
  ////////////////////////////////////////////////////////////////////
  // counting steps and wraps in the mode without reloads, and no count on a phase error in any mode
  a_step_up_one: assert property (count_pulse && count_direction && wm &&
    $past(position_counter) != position_maximum |-> position_counter == $past(position_counter) + 32'h1)
    else $error("up step wrong");
  a_step_down_one: assert property (count_pulse && !count_direction && wm &&
    $past(position_counter) != 32'h0 |-> position_counter == $past(position_counter) - 32'h1)
    else $error("down step wrong");
  a_wrap_up_zero: assert property (count_pulse && count_direction && wm &&
    $past(position_counter) == position_maximum |->
    position_counter == 32'h0 && interrupt_flag_reg.overflow_flag) else $error("overflow wrong");
  a_wrap_down_max: assert property (count_pulse && !count_direction && wm &&
    $past(position_counter) == 32'h0 |->
    position_counter == position_maximum && interrupt_flag_reg.underflow_flag)
    else $error("underflow wrong");
  a_phase_no_count: assert property ($rose(interrupt_flag_reg.phase_error_flag) |->
    !count_pulse) else $error("count on phase error");
  ////////////////////////////////////////////////////////////////////
  // index marker error status and its sticky flag
  a_latch_err_stat: assert property ($changed(index_latch_reg) &&
    counter_control_reg.reset_mode_field == 2'h0 |-> counter_status_reg.counter_error_status ==
    (index_latch_reg != 32'h0 && index_latch_reg != position_maximum)) else $error("error status");
  a_err_flag_set: assert property ($rose(counter_status_reg.counter_error_status) |->
    interrupt_flag_reg.counter_error_irq_flag) else $error("error flag not set");
  a_err_flag_sticky: assert property (interrupt_flag_reg.counter_error_irq_flag &&
    !flag_clear.counter_error_irq_flag |=> interrupt_flag_reg.counter_error_irq_flag)
    else $error("error flag dropped");
endmodule
bind qpc_counter qpc_counter_asserts u_chk (.mclk, .reset, .decoder_control_reg,
  .counter_control_reg, .position_maximum, .position_compare_value, .flag_clear,
  .position_counter, .index_latch_reg, .count_pulse, .count_direction, .counter_status_reg,
  .interrupt_flag_reg, .compare_sync, .index_pin_oe, .strobe_pin_oe);

// ### test/qpc_counter_tb.sv
// testbench of the position counter: sources, wraps, compare pins, markers
// assumes the encoder model and the bound checker are compiled with it
`timescale 1ns/1ps
module qpc_counter_tb;
  import qpc_pkg::*;
  logic mclk;
  logic reset;
  logic pa, pb, pi, ps; // encoder pins
  qpc_dec_ctl_t dec;
  qpc_cnt_ctl_t cctl;
  logic [31:0] pmax, pcmp, cnt, ilat;
  logic ut; // unit timer pulse
  qpc_flags_t fclr, flg;
  qpc_status_t sts;
  logic cpul, cdir, csync, ipo, ipoe, spo, spoe, slev;
  int err_total;
  int total_checks;
  qpc_encoder_model enc (.mclk(mclk), .phase_a(pa), .phase_b(pb), .index_out(pi),
    .strobe_out(ps));
  qpc_counter dut (.mclk(mclk), .reset(reset), .phase_a_input(pa), .phase_b_input(pb),
    .index_input(pi), .strobe_input(ps), .decoder_control_reg(dec),
    .counter_control_reg(cctl), .position_maximum(pmax), .position_compare_value(pcmp),
    .unit_timeout(ut), .flag_clear(fclr), .position_counter(cnt), .index_latch_reg(ilat),
    .count_pulse(cpul), .count_direction(cdir), .counter_status_reg(sts),
    .interrupt_flag_reg(flg), .compare_sync(csync), .index_pin_out(ipo),
    .index_pin_oe(ipoe), .strobe_pin_out(spo), .strobe_pin_oe(spoe), .strobe_level(slev));
  ////////////////////////////////////////////////////////////////////
  // 10 mhz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // compare one value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // pipeline is four edges deep; six cycles leaves margin
  task automatic settle();
    repeat (6) @(negedge mclk);
  endtask
  // one-cycle clear strobe for every flag
  task automatic clr();
    fclr = 6'h3f;
    @(negedge mclk);
    fclr = 6'h00;
    settle();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_total = 0;
    total_checks = 0;
    reset = 1'b1;
    dec = '0;
    cctl = '0;
    cctl.reset_mode_field = 2'h1;
    pmax = 32'hf;
    pcmp = 32'h100;
    ut = 1'b0;
    fclr = '0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    settle();
    chk("cnt_rst", cnt, 32'h0);
    chk("dir_rst", cdir, 32'h1);
    chk("flags_rst", flg, 32'h0);
    chk("status_rst", sts, 32'h0);
    // quadrature x4 and wraps both ways
    enc.step(1'b1, 4);
    chk("quad_up", cnt, 32'h4);
    chk("quad_dir_up", cdir, 32'h1);
    enc.step(1'b0, 6);
    chk("quad_wrap_down", cnt, 32'he);
    chk("quad_dir_down", cdir, 32'h0);
    chk("underflow", flg.underflow_flag, 32'h1);
    enc.step(1'b1, 2);
    chk("wrap_up", cnt, 32'h0);
    chk("overflow", flg.overflow_flag, 32'h1);
    clr();
    chk("flags_clear", flg, 32'h0);
    // swapped phases reverse the count
    dec.swap = 1'b1;
    enc.step(1'b1, 2);
    chk("swap_cnt", cnt, 32'he);
    dec.swap = 1'b0;
    // both phases in one sample
    enc.both();
    chk("phase_err", flg.phase_error_flag, 32'h1);
    chk("phase_err_cnt", cnt, 32'he);
    clr();
    // up source, single then double resolution
    pmax = 32'hff;
    dec.count_source_select = 2'h2;
    enc.tog_a(4);
    chk("up_single", cnt, 32'h10);
    chk("up_dir", cdir, 32'h1);
    dec.double_resolution_bit = 1'b1;
    enc.tog_a(4);
    chk("up_double", cnt, 32'h14);
    // down source, double then single
    dec.count_source_select = 2'h3;
    enc.tog_a(4);
    chk("down_double", cnt, 32'h10);
    chk("down_dir", cdir, 32'h0);
    dec.double_resolution_bit = 1'b0;
    enc.tog_a(4);
    chk("down_single", cnt, 32'he);
    // inverting a low pin gives a rise
    dec.count_source_select = 2'h2;
    dec.phase_a_invert = 1'b1;
    settle();
    chk("invert_rise", cnt, 32'hf);
    dec.phase_a_invert = 1'b0;
    settle();
    chk("invert_fall", cnt, 32'hf);
    // direction source: a clocks, b level steers
    dec.count_source_select = 2'h1;
    enc.set_b(1'b1);
    enc.tog_a(6);
    chk("dir_up", cnt, 32'h12);
    dec.phase_b_invert = 1'b1;
    enc.tog_a(4);
    chk("dir_down", cnt, 32'h10);
    chk("dir_level", cdir, 32'h0);
    // compare match routed to each pin
    pcmp = 32'h11;
    dec.sync_output_enable = 1'b1;
    dec.phase_b_invert = 1'b0;
    enc.tog_a(2);
    chk("cmp_sync", csync, 32'h1);
    chk("cmp_flag", flg.compare_match_flag, 32'h1);
    chk("idx_pin", {ipoe, ipo, spoe}, 32'h6);
    dec.sync_pin_select = 1'b1;
    settle();
    chk("stb_pin", {ipoe, spoe, spo}, 32'h3);
    dec.sync_output_enable = 1'b0;
    // reset mid-run with pins low, then reset-on-index in quadrature
    enc.set_b(1'b0);
    reset = 1'b1;
    dec = '0;
    cctl = '0;
    pmax = 32'hf;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    settle();
    chk("cnt_rst2", cnt, 32'h0);
    enc.step(1'b1, 3);
    enc.idx();
    enc.step(1'b1, 1);
    chk("mark_clear", cnt, 32'h0);
    chk("mark_latch", ilat, 32'h3);
    chk("first_mark", sts, 32'hf);
    chk("err_flag", flg.counter_error_irq_flag, 32'h1);
    enc.step(1'b1, 15);
    chk("no_mark", cnt, 32'hf);
    enc.idx();
    enc.step(1'b1, 1);
    chk("mark2_clear", cnt, 32'h0);
    chk("mark2_latch", ilat, 32'hf);
    chk("mark2_stat", sts, 32'he);
    chk("err_sticky", flg.counter_error_irq_flag, 32'h1);
    enc.idx();
    enc.step(1'b0, 1);
    chk("rev_mark_max", cnt, 32'hf);
    chk("rev_latch", ilat, 32'h0);
    chk("rev_stat", sts, 32'hc);
    chk("rev_no_uf", flg.underflow_flag, 32'h0);
    // unit reload, index rise latch
    cctl = {2'h3, 2'h1};
    enc.step(1'b0, 1);
    ut = 1'b1;
    @(negedge mclk);
    ut = 1'b0;
    settle();
    chk("unit_reload", cnt, 32'hf);
    dec.index_invert_bit = 1'b1;
    enc.stb(1'b1);
    chk("idx_inv_latch", ilat, 32'hf);
    chk("stb_level", slev, 32'h1);
    clr();
    chk("err_cleared", flg.counter_error_irq_flag, 32'h0);
    summarize();
  end
endmodule
